/* File: pkg/gateway_pkg.sv */
// Register map, field layout and timing constants of the gateway block
package gateway_pkg;
  localparam logic [7:0] IRQ_SRC_ADDR    = 8'h00;
  localparam logic [7:0] PIN_SEL_ADDR    = 8'h0B;
  localparam logic [7:0] INTENSITY_ADDR  = 8'h0C;
  localparam logic [7:0] WIN_CFG_ADDR    = 8'h0D;
  localparam logic [7:0] WIN_BASE_ADDR   = 8'h0E;
  localparam logic [7:0] KEY_HIGH_ADDR   = 8'hAC;
  localparam logic [7:0] KEY_LOW_ADDR    = 8'hAD;
  localparam logic [7:0] RESTART_ADDR    = 8'hB1;
  localparam logic [7:0] WIN_LAST_ADDR   = 8'h07;
  localparam int         SEL_MSB         = 2;
  localparam int         CFG_MODE_LSB    = 4;
  localparam int         CFG_DIR_BIT     = 3;
  localparam int         IRQ_BURN_BIT    = 6;
  localparam int         IRQ_SPM_BIT     = 5;
  localparam logic [2:0] SEL_RESET       = 3'h0;
  localparam logic [1:0] MODE_OFF        = 2'h0;
  localparam logic [1:0] MODE_ON         = 2'h1;
  localparam logic       DIR_WRITE       = 1'b0;
  localparam logic [7:0] BASE_RESET      = 8'h00;
  localparam logic [7:0] BASE_MASK       = 8'h78;
  localparam logic [7:0] RESTART_FIRST   = 8'hDE;
  localparam logic [7:0] RESTART_SECOND  = 8'h00;
  localparam logic [7:0] KEY_HIGH_VALUE  = 8'h62;
  localparam logic [7:0] KEY_LOW_VALUE   = 8'h9D;
  localparam logic [7:0] BURN_FIRST      = 8'hA5;
  localparam logic [7:0] BURN_SECOND     = 8'h5A;
  localparam logic [1:0] OPMODE_SLEEP    = 2'h2;
  localparam int         PINS            = 8;
  localparam int         BURST_BYTES     = 8;
  localparam int         SPM_BYTES       = 128;
  localparam int         CLK_HZ          = 50_000_000;
  localparam int         SLEEP_APPLY_MS  = 30;
  localparam int         SLEEP_APPLY_CYC = SLEEP_APPLY_MS * (CLK_HZ / 1000);
  localparam int         BUF_WIDTH       = 8;
endpackage

/* File: pkg/buf_if.sv */
// Valid/ready carrier between the register core and its read-data buffer
`timescale 1ns/100ps
interface buf_if #(parameter int WIDTH = 8);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user   (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: verilog/two_entry_buf.sv */
// Two-entry registered buffer, every output straight from a flop
`timescale 1ns/100ps
module two_entry_buf
  import gateway_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  buf_if.buffer    port
);
  logic             head_valid_reg;
  logic             tail_valid_reg;
  logic [BUF_WIDTH-1:0] head_data_reg;
  logic [BUF_WIDTH-1:0] tail_data_reg;
  logic             push;
  logic             pop;
  logic             in_ready_reg;

  assign push          = port.in_valid && !tail_valid_reg;
  assign pop           = head_valid_reg && port.out_ready;
  // Own flop, so ready leaves the block with no inverter behind it
  assign port.in_ready = in_ready_reg;
  assign port.out_valid = head_valid_reg;
  assign port.out_data = head_data_reg;

  // Head refills from the tail first so word order is kept
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      head_valid_reg <= 1'b0;
      tail_valid_reg <= 1'b0;
      head_data_reg  <= '0;
      tail_data_reg  <= '0;
      in_ready_reg   <= 1'b1;
    end else begin
      if (!head_valid_reg || pop) begin
        in_ready_reg   <= 1'b1;
        head_valid_reg <= tail_valid_reg || push;
        head_data_reg  <= tail_valid_reg ? tail_data_reg : port.in_data;
        tail_valid_reg <= tail_valid_reg && push;
        if (push) begin
          tail_data_reg <= port.in_data;
        end
      end else if (push) begin
        in_ready_reg   <= 1'b0;
        tail_valid_reg <= 1'b1;
        tail_data_reg  <= port.in_data;
      end
    end
  end

  full_no_push_a: assert property (@(posedge core_clk) disable iff (reset)
    tail_valid_reg && !pop |=> tail_valid_reg && $stable(tail_data_reg))
    else $error("Buffer lost a stored word");
endmodule

/* File: verilog/param_gateway_led_regs.sv */
// Host registers: output pin intensity, restart, parameter window and burn keys
`timescale 1ns/100ps
module param_gateway_led_regs
  import gateway_pkg::*;
#(
  parameter int SLEEP_APPLY_CYCLES = SLEEP_APPLY_CYC
)(
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                i2c_stop,
  output wire logic                reg_rd_ready,
  output wire logic                rd_valid,
  output wire logic [7:0]          rd_data,
  input  wire logic                rd_ready,
  input  wire logic [1:0]          op_mode,
  input  wire logic [7:0]          lit_level,
  input  wire logic [7:0]          dark_level,
  input  wire logic [PINS-1:0]     output_powerup_state,
  input  wire logic                burn_done,
  output logic [PINS*8-1:0]        pwm_output_pin_level,
  output logic                     irq_out_n,
  output logic                     chip_restart,
  output logic                     burn_start
);
  typedef enum logic [1:0] {BURN_IDLE, BURN_GOT_FIRST, BURN_ARMED} burn_state_t;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  buf_if #(.WIDTH(BUF_WIDTH)) rd_bus ();

  logic [7:0]        spm_mem [SPM_BYTES];
  logic [7:0]        stage_reg [BURST_BYTES];
  logic [7:0]        intensity_reg [PINS];
  logic [BURST_BYTES-1:0] stage_mask_reg;
  logic [2:0]        pin_sel_reg;
  logic [1:0]        win_mode_reg;
  logic              win_dir_reg;
  logic [7:0]        win_base_reg;
  logic [7:0]        apply_base_reg;
  logic              init_done_reg;
  logic [1:0]        irq_flags_reg;
  logic [1:0]        irq_flags_next;
  logic              restart_armed_reg;
  logic              key_high_ok_reg;
  logic              key_low_ok_reg;
  burn_state_t       burn_state_reg;
  logic              sleep_wait_reg;
  logic [31:0]       sleep_cnt_reg;
  logic              wr_hit;
  logic              rd_take;
  logic              win_on;
  logic              win_addr;
  logic              burst_close;
  logic              apply_now;
  logic              apply_enter_sleep;
  logic [7:0]        rd_word;
  logic [7:0]        mem_base;

  assign win_on   = (win_mode_reg == MODE_ON);
  assign win_addr = win_on && (reg_addr <= WIN_LAST_ADDR);
  assign wr_hit   = reg_wr;
  assign rd_take  = reg_rd && rd_bus.in_ready;

  // Closing write turns the window off; only a full burst is applied
  assign burst_close = wr_hit && reg_addr == WIN_CFG_ADDR && win_on
                       && win_dir_reg == DIR_WRITE && reg_wdata[5:4] == MODE_OFF
                       && stage_mask_reg == '1 && !sleep_wait_reg;
  // Writes are taken in any mode; sleep defers the commit and raises no flag for it
  assign apply_enter_sleep = burst_close && op_mode == OPMODE_SLEEP;
  assign apply_now = (burst_close && op_mode != OPMODE_SLEEP)
                     || (sleep_wait_reg && sleep_cnt_reg == 32'h0);

  // Immediate commit uses the live base; the latched one is only ready next edge
  assign mem_base = sleep_wait_reg ? apply_base_reg : win_base_reg;

  // Pin selector keeps only bits 2:0, upper bits dropped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_sel_reg <= SEL_RESET;
    end else if (wr_hit && !win_addr && reg_addr == PIN_SEL_ADDR) begin
      pin_sel_reg <= reg_wdata[SEL_MSB:0];
    end
  end

  // Power-up levels caught on the first edge after release
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      init_done_reg <= 1'b0;
      for (int i = 0; i < PINS; i++) begin
        intensity_reg[i] <= 8'h00;
      end
    end else if (!init_done_reg) begin
      init_done_reg <= 1'b1;
      for (int i = 0; i < PINS; i++) begin
        intensity_reg[i] <= output_powerup_state[i] ? lit_level : dark_level;
      end
    end else if (wr_hit && !win_addr && reg_addr == INTENSITY_ADDR) begin
      intensity_reg[pin_sel_reg] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pwm_output_pin_level <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        pwm_output_pin_level[i*8 +: 8] <= intensity_reg[i];
      end
    end
  end

  // Window configuration; reserved bits are not stored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      win_mode_reg <= MODE_OFF;
      win_dir_reg  <= DIR_WRITE;
    end else if (wr_hit && !win_addr && reg_addr == WIN_CFG_ADDR) begin
      win_mode_reg <= reg_wdata[CFG_MODE_LSB +: 2];
      win_dir_reg  <= reg_wdata[CFG_DIR_BIT];
    end
  end

  // Base forced onto an eight-byte boundary within range
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      win_base_reg <= BASE_RESET;
    end else if (wr_hit && !win_addr && reg_addr == WIN_BASE_ADDR) begin
      win_base_reg <= reg_wdata & BASE_MASK;
    end
  end

  // Burst staging: bytes gather here, memory only changes on commit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage_mask_reg <= '0;
      for (int i = 0; i < BURST_BYTES; i++) begin
        stage_reg[i] <= 8'h00;
      end
    end else if (wr_hit && win_addr && win_dir_reg == DIR_WRITE) begin
      stage_reg[reg_addr[2:0]]      <= reg_wdata;
      stage_mask_reg[reg_addr[2:0]] <= 1'b1;
    end else if (wr_hit && !win_addr && reg_addr == WIN_CFG_ADDR) begin
      stage_mask_reg <= '0;
    end
  end

  // Commit target latched at close so a new base cannot move it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      apply_base_reg <= BASE_RESET;
    end else if (burst_close) begin
      apply_base_reg <= win_base_reg;
    end
  end

  // Sleep commit delay; a long count, shortened by parameter in simulation
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sleep_wait_reg <= 1'b0;
      sleep_cnt_reg  <= 32'h0;
    end else if (apply_enter_sleep) begin
      sleep_wait_reg <= 1'b1;
      sleep_cnt_reg  <= 32'(SLEEP_APPLY_CYCLES - 1);
    end else if (sleep_wait_reg) begin
      if (sleep_cnt_reg == 32'h0) begin
        sleep_wait_reg <= 1'b0;
      end else begin
        sleep_cnt_reg <= sleep_cnt_reg - 32'h1;
      end
    end
  end

  // Eight bytes land together at base plus offset; no reset, plain memory
  always_ff @(posedge core_clk) begin
    if (apply_now) begin
      for (int i = 0; i < BURST_BYTES; i++) begin
        spm_mem[{mem_base[6:3], 3'(i)}] <= stage_reg[i];
      end
    end
  end

  // Set wins over the read clear; sleep commits raise no flag
  always_comb begin
    irq_flags_next = irq_flags_reg;
    if (rd_take && !win_addr && reg_addr == IRQ_SRC_ADDR) begin
      irq_flags_next = 2'b00;
    end
    if (apply_now && !sleep_wait_reg) begin
      irq_flags_next[0] = 1'b1;
    end
    if (burn_done) begin
      irq_flags_next[1] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_flags_reg <= 2'b00;
      irq_out_n     <= 1'b1;
    end else begin
      irq_flags_reg <= irq_flags_next;
      irq_out_n     <= ~|irq_flags_next;
    end
  end

  // Restart needs the two writes in a row at the restart register; writes to other registers in between do not disarm it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      restart_armed_reg <= 1'b0;
      chip_restart      <= 1'b0;
    end else begin
      chip_restart <= 1'b0;
      if (wr_hit && reg_addr == RESTART_ADDR) begin
        restart_armed_reg <= (reg_wdata == RESTART_FIRST);
        chip_restart      <= restart_armed_reg && reg_wdata == RESTART_SECOND;
      end
    end
  end

  // Keys only checked here; the host owes the right values
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      key_high_ok_reg <= 1'b0;
      key_low_ok_reg  <= 1'b0;
    end else if (burn_start) begin
      key_high_ok_reg <= 1'b0;
      key_low_ok_reg  <= 1'b0;
    end else if (wr_hit && reg_addr == KEY_HIGH_ADDR) begin
      key_high_ok_reg <= (reg_wdata == KEY_HIGH_VALUE);
    end else if (wr_hit && reg_addr == KEY_LOW_ADDR) begin
      key_low_ok_reg <= (reg_wdata == KEY_LOW_VALUE);
    end
  end

  // Burn trigger waits for the STOP, so a stray base write aborts it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      burn_state_reg <= BURN_IDLE;
      burn_start     <= 1'b0;
    end else begin
      burn_start <= 1'b0;
      unique case (burn_state_reg)
        BURN_IDLE: begin
          if (wr_hit && reg_addr == WIN_BASE_ADDR && reg_wdata == BURN_FIRST
              && key_high_ok_reg && key_low_ok_reg) begin
            burn_state_reg <= BURN_GOT_FIRST;
          end
        end
        BURN_GOT_FIRST: begin
          if (wr_hit) begin
            burn_state_reg <= (reg_addr == WIN_BASE_ADDR && reg_wdata == BURN_SECOND)
                              ? BURN_ARMED : BURN_IDLE;
          end
        end
        BURN_ARMED: begin
          if (i2c_stop) begin
            burn_start     <= 1'b1;
            burn_state_reg <= BURN_IDLE;
          end else if (wr_hit) begin
            burn_state_reg <= BURN_IDLE;
          end
        end
      endcase
    end
  end

  // Read mux; window reads come from memory in any mode, zero while the window is set to write
  always_comb begin
    rd_word = 8'h00;
    if (win_addr) begin
      rd_word = (win_dir_reg != DIR_WRITE) ? spm_mem[{win_base_reg[6:3], reg_addr[2:0]}]
                                           : 8'h00;
    end else begin
      unique case (reg_addr)
        IRQ_SRC_ADDR:   rd_word = {1'b0, irq_flags_reg[1], irq_flags_reg[0], 5'h00};
        PIN_SEL_ADDR:   rd_word = {5'h00, pin_sel_reg};
        INTENSITY_ADDR: rd_word = intensity_reg[pin_sel_reg];
        WIN_CFG_ADDR:   rd_word = {2'h0, win_mode_reg, win_dir_reg, 3'h0};
        WIN_BASE_ADDR:  rd_word = win_base_reg;
        default:        rd_word = 8'h00;
      endcase
    end
  end

  assign rd_bus.in_valid  = reg_rd;
  assign rd_bus.in_data   = rd_word;
  assign rd_bus.out_ready = rd_ready;
  assign reg_rd_ready     = rd_bus.in_ready;
  assign rd_valid         = rd_bus.out_valid;
  assign rd_data          = rd_bus.out_data;

  two_entry_buf u_rd_buf (
    .core_clk (core_clk),
    .reset    (reset),
    .port     (rd_bus.buffer)
  );

  sel_store_a: assert property (wr_hit && !win_addr && reg_addr == PIN_SEL_ADDR
    |=> pin_sel_reg == $past(reg_wdata[2:0])) else $error("Selector not stored");
  intens_read_a: assert property (rd_take && !win_addr && reg_addr == INTENSITY_ADDR
    |-> rd_bus.in_data == intensity_reg[pin_sel_reg]) else $error("Wrong pin intensity");
  restart_only_a: assert property (chip_restart
    |-> $past(wr_hit && reg_addr == RESTART_ADDR && reg_wdata == RESTART_SECOND, 1)
        && $past(restart_armed_reg, 1)) else $error("Restart without sequence");
  cfg_field_a: assert property (wr_hit && !win_addr && reg_addr == WIN_CFG_ADDR
    |=> win_mode_reg == $past(reg_wdata[5:4]) && win_dir_reg == $past(reg_wdata[3]))
    else $error("Config not stored");
  base_align_a: assert property ((win_base_reg & ~BASE_MASK) == 8'h00)
    else $error("Base off boundary");
  partial_burst_a: assert property (wr_hit && reg_addr == WIN_CFG_ADDR
    && stage_mask_reg != '1 && !sleep_wait_reg |=> !irq_flags_reg[0] || $past(irq_flags_reg[0]))
    else $error("Partial burst applied");
  apply_flag_a: assert property (burst_close && op_mode != OPMODE_SLEEP
    |=> irq_flags_reg[0] ##1 !irq_out_n) else $error("Write flag missing");
  read_clear_a: assert property (rd_take && !win_addr && reg_addr == IRQ_SRC_ADDR
    && !apply_now && !burn_done |=> irq_flags_reg == 2'b00) else $error("Flags not cleared");
  irq_pin_a: assert property (irq_out_n == ~|irq_flags_reg)
    else $error("Interrupt pin mismatch");
  burn_go_a: assert property (burn_start
    |-> $past(burn_state_reg == BURN_ARMED && i2c_stop)) else $error("Burn without sequence");
endmodule

/* File: testbench/host_model.sv */
// Host model: register-port master of the gateway block
`timescale 1ns/100ps
module host_model
  import gateway_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reg_rd_ready,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            i2c_stop,
  output logic            rd_ready
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    i2c_stop  = 1'b0;
    rd_ready  = 1'b1;
  end

  // Consumer side of the read buffer, changed only here
  task automatic set_ready(input logic v);
    rd_ready = v;
  endtask

  // One write strobe, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  // Request held until taken; bounded so a stuck ready cannot hang
  task automatic req(input logic [7:0] a);
    int n;
    @(negedge core_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    n = 0;
    while (reg_rd_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask

  task automatic pop(output logic [7:0] d);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req(a);
    pop(d);
  endtask

  // Fewer than eight bytes only when a partial burst is wanted
  task automatic burst_wr(input logic [7:0] base, input logic [63:0] d, input int n);
    wr(WIN_CFG_ADDR, 8'h10);
    wr(WIN_BASE_ADDR, base);
    for (int k = 0; k < n; k++) begin
      wr(8'(k), d[8*k+:8]);
    end
    wr(WIN_CFG_ADDR, 8'h00);
  endtask

  task automatic burst_rd(input logic [7:0] base, output logic [63:0] d);
    logic [7:0] b;
    wr(WIN_CFG_ADDR, 8'h18);
    wr(WIN_BASE_ADDR, base);
    for (int k = 0; k < BURST_BYTES; k++) begin
      rd(8'(k), b);
      d[8*k+:8] = b;
    end
    wr(WIN_CFG_ADDR, 8'h00);
  endtask

  task automatic restart(input logic [7:0] second);
    wr(RESTART_ADDR, RESTART_FIRST);
    wr(RESTART_ADDR, second);
  endtask

  task automatic burn(input logic [7:0] key_high);
    wr(KEY_HIGH_ADDR, key_high);
    wr(KEY_LOW_ADDR, KEY_LOW_VALUE);
    wr(WIN_BASE_ADDR, BURN_FIRST);
    wr(WIN_BASE_ADDR, BURN_SECOND);
    @(negedge core_clk);
    i2c_stop = 1'b1;
    @(negedge core_clk);
    i2c_stop = 1'b0;
  endtask
endmodule

/* File: testbench/param_gateway_led_regs_tb.sv */
// Self-checking bench for the gateway register block
`timescale 1ns/100ps
module param_gateway_led_regs_tb;
  import gateway_pkg::*;
  localparam int SLEEP_CYC = 16;
  logic            core_clk, reset, reg_wr, reg_rd, i2c_stop, rd_ready, burn_done;
  logic            reg_rd_ready, rd_valid, irq_out_n, chip_restart, burn_start;
  logic [7:0]      reg_addr, reg_wdata, rd_data, lit_level, dark_level, b, base;
  logic [1:0]      op_mode;
  logic [PINS-1:0] output_powerup_state;
  logic [PINS*8-1:0] pwm_output_pin_level;
  logic [7:0]      lvl [PINS];
  logic [63:0]     d, d0, q;
  logic [31:0]     seed;
  int              bad_count, tests_run, restart_cnt, burn_cnt;

  param_gateway_led_regs #(.SLEEP_APPLY_CYCLES(SLEEP_CYC)) dut (
    .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .i2c_stop(i2c_stop),
    .reg_rd_ready(reg_rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_ready(rd_ready), .op_mode(op_mode), .lit_level(lit_level),
    .dark_level(dark_level), .output_powerup_state(output_powerup_state),
    .burn_done(burn_done), .pwm_output_pin_level(pwm_output_pin_level),
    .irq_out_n(irq_out_n), .chip_restart(chip_restart), .burn_start(burn_start));

  host_model host (
    .core_clk(core_clk), .reg_rd_ready(reg_rd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .i2c_stop(i2c_stop), .rd_ready(rd_ready));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] pin_default(input int i);
    return output_powerup_state[i] ? lit_level : dark_level;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always #10 core_clk = ~core_clk;

  // Pulses counted mid-cycle, so a double pulse is caught too
  always @(negedge core_clk) begin
    if (chip_restart === 1'b1) restart_cnt++;
    if (burn_start === 1'b1) burn_cnt++;
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    burn_done = 1'b0;
    op_mode = 2'h0;
    seed = lfsr(32'hD2F24E88);
    lit_level = seed[7:0];
    dark_level = seed[15:8];
    output_powerup_state = seed[23:16];
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < PINS; i++) begin
      check(pwm_output_pin_level[8*i+:8], pin_default(i));
    end
    host.rd(PIN_SEL_ADDR, b);
    check(b, SEL_RESET);
    host.rd(INTENSITY_ADDR, b);
    check(b, pin_default(0));
    host.rd(WIN_BASE_ADDR, b);
    check(b, BASE_RESET);
    host.rd(WIN_CFG_ADDR, b);
    check(b, 8'h00);
    // Junk in the reserved selector bits must not move the selection
    for (int i = PINS - 1; i >= 0; i--) begin
      seed = lfsr(seed);
      lvl[i] = (i == 7) ? 8'hFF : seed[15:8];
      host.wr(PIN_SEL_ADDR, {seed[7:3], 3'(i)});
      host.wr(INTENSITY_ADDR, lvl[i]);
    end
    for (int i = 0; i < PINS; i++) begin
      host.wr(PIN_SEL_ADDR, 8'(i));
      host.rd(PIN_SEL_ADDR, b);
      check(b, 8'(i));
      host.rd(INTENSITY_ADDR, b);
      check(b, lvl[i]);
      check(pwm_output_pin_level[8*i+:8], lvl[i]);
    end
    host.wr(WIN_CFG_ADDR, 8'hC7);
    host.rd(WIN_CFG_ADDR, b);
    check(b, 8'h00);
    host.wr(WIN_BASE_ADDR, 8'hFF);
    host.rd(WIN_BASE_ADDR, b);
    check(b, 8'h78);
    // Write in active, doze, sleep; read back in another mode
    for (int m = 0; m < 3; m++) begin
      seed = lfsr(seed);
      d[31:0] = seed;
      seed = lfsr(seed);
      d[63:32] = seed;
      base = (m == 0) ? 8'h78 : 8'(8 * m);
      op_mode = 2'(m);
      host.burst_wr(base, d, BURST_BYTES);
      if (m < 2) begin
        repeat (2) @(negedge core_clk);
        check(irq_out_n, 1'b0);
        host.rd(IRQ_SRC_ADDR, b);
        check(b, 8'h20);
        check(irq_out_n, 1'b1);
      end else begin
        repeat (SLEEP_CYC + 4) @(negedge core_clk);
        check(irq_out_n, 1'b1);
      end
      op_mode = 2'((m + 1) % 3);
      host.burst_rd(base, q);
      check(q, d);
      if (m == 0) d0 = d;
    end
    // A seven-byte burst must leave memory and flags alone
    op_mode = 2'h0;
    host.burst_wr(8'h78, ~d0, 7);
    repeat (4) @(negedge core_clk);
    check(irq_out_n, 1'b1);
    host.burst_rd(8'h78, q);
    check(q, d0);
    host.restart(8'h01);
    host.wr(RESTART_ADDR, RESTART_SECOND);
    repeat (2) @(negedge core_clk);
    check(restart_cnt, 0);
    host.restart(RESTART_SECOND);
    repeat (2) @(negedge core_clk);
    check(restart_cnt, 1);
    host.burn(8'h61);
    repeat (3) @(negedge core_clk);
    check(burn_cnt, 0);
    host.burn(KEY_HIGH_VALUE);
    repeat (3) @(negedge core_clk);
    check(burn_cnt, 1);
    burn_done = 1'b1;
    @(negedge core_clk);
    burn_done = 1'b0;
    repeat (2) @(negedge core_clk);
    check(irq_out_n, 1'b0);
    host.rd(IRQ_SRC_ADDR, b);
    check(b, 8'h40);
    // Stalled consumer: buffer fills, refuses, then drains in order
    host.set_ready(1'b0);
    host.req(PIN_SEL_ADDR);
    host.req(INTENSITY_ADDR);
    @(negedge core_clk);
    check(reg_rd_ready, 1'b0);
    host.set_ready(1'b1);
    host.pop(b);
    check(b, 8'h07);
    host.pop(b);
    check(b, lvl[7]);
    check(rd_valid, 1'b0);
    tally_and_finish();
  end
endmodule
